// [design/hpa_pkg.sv]
/*
  Shared constants and types for the host port page-address block.
  Assumes a single 20 MHz clock and a byte-addressed register bus.
*/
`default_nettype none
package hpa_pkg;
  // ==========================================================
  // Register byte addresses
  localparam logic [31:0] HPA_CFG_ADDR   = 32'h4000_0008;
  localparam logic [31:0] HPA_TOP_ADDR   = 32'h4000_000c;
  localparam logic [31:0] HPA_UMID_ADDR  = 32'h4000_0010;
  // ==========================================================
  // Field layout and reset values
  localparam int          HPA_CFG_PAGE_BIT = 1;
  localparam int          HPA_CFG_SEP_BIT  = 2;
  localparam logic [7:0]  HPA_PAGE_RESET   = 8'h00;
  localparam logic [31:0] HPA_WORD_RESET   = 32'h0000_0000;
  localparam logic [31:0] HPA_ADDR_STEP    = 32'h0000_0004;
  localparam int          HPA_FIFO_DEPTH   = 4;
  // ==========================================================
  // Host access selects
  localparam logic [1:0] HPA_SEL_CTRL      = 2'h0;
  localparam logic [1:0] HPA_SEL_DATA_AUTO = 2'h1;
  localparam logic [1:0] HPA_SEL_ADDR      = 2'h2;
  localparam logic [1:0] HPA_SEL_DATA      = 2'h3;
  // ==========================================================
  // Host access sequencer
  typedef enum logic [2:0] {
    HPA_IDLE, HPA_FETCH, HPA_WAIT_FIFO, HPA_FLUSH, HPA_HOLD, HPA_WRITE
  } hpa_phase_t;
endpackage : hpa_pkg
`default_nettype wire

// [design/hpa_fifo_if.sv]
/*
  Link between the host port sequencer and its read prefetch FIFO.
  Assumes both ends share one clock.
*/
`default_nettype none
interface hpa_fifo_if #(parameter int WIDTH = 32);
  logic             push;
  logic [WIDTH-1:0] push_data;
  logic             pop;
  logic             flush;
  logic [WIDTH-1:0] pop_data;
  logic             empty;
  logic             full;
  modport fifo (input push, push_data, pop, flush, output pop_data, empty, full);
  modport user (output push, push_data, pop, flush, input pop_data, empty, full);
endinterface : hpa_fifo_if
`default_nettype wire

// [design/hpa_rd_fifo.sv]
/*
  Show-ahead read prefetch FIFO in flip-flops.
  Assumes the user pops only when not empty; flush wins over push.
*/
`default_nettype none
module hpa_rd_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Sequencer side
  hpa_fifo_if.fifo f
);
  localparam int PW = $clog2(DEPTH);
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
    $error("DEPTH must be a power of two of at least 2");
  end
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0]               wp;
    logic [PW-1:0]               rp;
    logic [PW:0]                 cnt;
  } hpa_fifo_st_t;
  hpa_fifo_st_t r_reg;
  hpa_fifo_st_t r_next;
  logic         do_push;
  logic         do_pop;

  assign f.empty    = (r_reg.cnt == '0);
  assign f.full     = (r_reg.cnt == (PW+1)'(DEPTH));
  assign f.pop_data = r_reg.mem[r_reg.rp];
  assign do_push    = f.push & ~f.full;
  assign do_pop     = f.pop & ~f.empty;

  always_comb begin
    r_next = r_reg;
    if (f.flush) begin
      r_next.wp  = '0;
      r_next.rp  = '0;
      r_next.cnt = '0;
    end else begin
      if (do_push) begin
        r_next.mem[r_reg.wp] = f.push_data;
        r_next.wp            = r_reg.wp + 1'b1;
      end
      if (do_pop) begin
        r_next.rp = r_reg.rp + 1'b1;
      end
      if (do_push && !do_pop) begin
        r_next.cnt = r_reg.cnt + 1'b1;
      end else if (do_pop && !do_push) begin
        r_next.cnt = r_reg.cnt - 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  no_overflow_a: assert property (@(posedge clk_in) disable iff (rst_in)
    f.full && !f.flush && !f.pop |=> f.full) else $error("FIFO count left full");
endmodule : hpa_rd_fifo
`default_nettype wire

// [design/hpa_host_port.sv]
/*
  Host port page-address and ready sequencing, with page registers on Avalon-MM.
  Assumes host inputs synchronous to clk_in and a memory port that
  answers each request with a one-cycle ack.
*/
// The implementer's own choice: the Avalon-MM interface to the registers.
`default_nettype none
module hpa_host_port
  import hpa_pkg::*;
#(
  parameter int FIFO_DEPTH = HPA_FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  // Avalon-MM register slave
  input  wire logic [31:0] av_address_in,
  input  wire logic        av_read_in,
  input  wire logic        av_write_in,
  input  wire logic [31:0] av_writedata_in,
  input  wire logic [3:0]  av_byteenable_in,
  output logic      [31:0] av_readdata_out,
  output logic             av_waitrequest_out,
  // Parallel host port
  input  wire logic        host_strobe_n_in,
  input  wire logic [1:0]  host_cntl_in,
  input  wire logic        host_rw_in,
  input  wire logic [15:0] host_addr_in,
  input  wire logic [31:0] host_data_in,
  output logic      [31:0] host_data_out,
  output logic             host_data_oe_out,
  output logic             host_ready_out,
  // Internal memory port
  output logic             mem_req_out,
  output logic             mem_we_out,
  output logic      [31:0] mem_addr_out,
  output logic      [31:0] mem_wdata_out,
  input  wire logic        mem_ack_in,
  input  wire logic [31:0] mem_rdata_in
);
  typedef struct packed {
    hpa_phase_t  st;
    logic        strobe_d;
    logic        rw;
    logic [1:0]  sel;
    logic [7:0]  top;
    logic [7:0]  umid;
    logic        page_mode;
    logic        sep_bus;
    logic [31:0] ctrl;
    logic [31:0] addr;
    logic [31:0] pf_addr;
    logic        autoinc;
    logic        issued;
    logic        mem_req;
    logic        mem_we;
    logic        mem_pf;
    logic [31:0] mem_addr;
    logic [31:0] wdata;
    logic [31:0] hdata;
    logic        av_ack;
    logic [31:0] av_rdata;
  } hpa_state_t;

  hpa_state_t r_reg;
  hpa_state_t r_next;
  logic        strobe_fall;
  logic        strobe_rise;
  logic        page_apply;
  logic [15:0] low16;
  logic [31:0] eff_addr;
  logic        mem_done;

  hpa_fifo_if #(.WIDTH(32)) fifo_bus ();
  hpa_rd_fifo #(.WIDTH(32), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_in (clk_in),
    .rst_in (rst_in),
    .f      (fifo_bus.fifo)
  );

  // ==========================================================
  // Address formation
  assign page_apply = r_reg.sep_bus | r_reg.page_mode;
  assign low16      = r_reg.sep_bus ? host_addr_in : r_reg.addr[15:0];
  assign eff_addr   = page_apply ? {r_reg.top, r_reg.umid, low16}
                                 : r_reg.addr;
  assign strobe_fall = r_reg.strobe_d & ~host_strobe_n_in;
  assign strobe_rise = ~r_reg.strobe_d & host_strobe_n_in;
  assign mem_done    = r_reg.mem_req & mem_ack_in;

  // Prefetch returns go straight into the FIFO
  assign fifo_bus.push      = mem_done & r_reg.mem_pf;
  assign fifo_bus.push_data = mem_rdata_in;

  always_comb begin
    r_next          = r_reg;
    fifo_bus.pop    = 1'b0;
    fifo_bus.flush  = 1'b0;
    r_next.strobe_d = host_strobe_n_in;
    if (mem_done) begin
      r_next.mem_req = 1'b0;
    end
    // ========================================================
    // Register slave: one wait cycle, then the answer
    r_next.av_ack = 1'b0;
    if ((av_read_in || av_write_in) && !r_reg.av_ack) begin
      r_next.av_ack   = 1'b1;
      r_next.av_rdata = HPA_WORD_RESET;
      case (av_address_in)
        HPA_CFG_ADDR: begin
          r_next.av_rdata[HPA_CFG_PAGE_BIT] = r_reg.page_mode;
          r_next.av_rdata[HPA_CFG_SEP_BIT]  = r_reg.sep_bus;
          if (av_write_in && av_byteenable_in[0]) begin
            r_next.page_mode = av_writedata_in[HPA_CFG_PAGE_BIT];
            r_next.sep_bus   = av_writedata_in[HPA_CFG_SEP_BIT];
          end
        end
        HPA_TOP_ADDR: begin
          r_next.av_rdata[7:0] = r_reg.top;
          if (av_write_in && av_byteenable_in[0]) begin
            r_next.top = av_writedata_in[7:0];
          end
        end
        HPA_UMID_ADDR: begin
          r_next.av_rdata[7:0] = r_reg.umid;
          if (av_write_in && av_byteenable_in[0]) begin
            r_next.umid = av_writedata_in[7:0];
          end
        end
        default: r_next.av_rdata = HPA_WORD_RESET;
      endcase
    end
    // ========================================================
    // Host access sequencer
    case (r_reg.st)
      HPA_IDLE: begin
        if (strobe_fall) begin
          r_next.sel = host_cntl_in;
          r_next.rw  = host_rw_in;
          r_next.st  = HPA_HOLD;
          if (host_rw_in) begin
            case (host_cntl_in)
              HPA_SEL_CTRL: r_next.hdata = r_reg.ctrl;
              HPA_SEL_ADDR: r_next.hdata = r_reg.addr;
              HPA_SEL_DATA: begin
                r_next.autoinc = 1'b0;
                r_next.st      = HPA_FETCH;
              end
              default: begin
                if (!r_reg.autoinc) begin
                  r_next.autoinc = 1'b1;
                  r_next.pf_addr = eff_addr;
                end
                if (!fifo_bus.empty) begin
                  fifo_bus.pop = 1'b1;
                  r_next.hdata = fifo_bus.pop_data;
                end else begin
                  r_next.st = HPA_WAIT_FIFO;
                end
              end
            endcase
          end else if (host_cntl_in == HPA_SEL_ADDR) begin
            r_next.autoinc = 1'b0;
            if (!fifo_bus.empty || r_reg.mem_req) begin
              r_next.st = HPA_FLUSH;
            end
          end
        end
      end
      HPA_FETCH: begin
        if (!r_reg.mem_req && !r_reg.issued) begin
          r_next.issued   = 1'b1;
          r_next.mem_req  = 1'b1;
          r_next.mem_we   = 1'b0;
          r_next.mem_pf   = 1'b0;
          r_next.mem_addr = eff_addr;
        end
        if (mem_done && !r_reg.mem_pf) begin
          r_next.hdata  = mem_rdata_in;
          r_next.issued = 1'b0;
          r_next.st     = HPA_HOLD;
        end
      end
      HPA_WAIT_FIFO: begin
        if (!fifo_bus.empty) begin
          fifo_bus.pop = 1'b1;
          r_next.hdata = fifo_bus.pop_data;
          r_next.st    = HPA_HOLD;
        end
      end
      HPA_FLUSH: begin
        // Wait out a prefetch in flight so it cannot refill the FIFO
        if (!r_reg.mem_req) begin
          fifo_bus.flush = 1'b1;
          r_next.st      = HPA_HOLD;
        end
      end
      HPA_HOLD: begin
        if (!host_strobe_n_in) begin
          r_next.wdata = host_data_in;
        end
        if (strobe_rise) begin
          r_next.st = HPA_IDLE;
          if (!r_reg.rw) begin
            case (r_reg.sel)
              HPA_SEL_CTRL: r_next.ctrl = r_reg.wdata;
              HPA_SEL_ADDR: begin
                if (page_apply) begin
                  r_next.addr[15:0] = r_reg.wdata[15:0];
                end else begin
                  r_next.addr = r_reg.wdata;
                end
              end
              default: begin
                r_next.autoinc = 1'b0;
                r_next.st      = HPA_WRITE;
              end
            endcase
          end
        end
      end
      HPA_WRITE: begin
        if (!r_reg.mem_req && !r_reg.issued) begin
          r_next.issued   = 1'b1;
          r_next.mem_req  = 1'b1;
          r_next.mem_we   = 1'b1;
          r_next.mem_pf   = 1'b0;
          r_next.mem_addr = eff_addr;
        end
        if (mem_done && !r_reg.mem_pf) begin
          r_next.issued = 1'b0;
          r_next.st     = HPA_IDLE;
          if (r_reg.sel == HPA_SEL_DATA_AUTO) begin
            r_next.addr = r_reg.addr + HPA_ADDR_STEP;
          end
        end
      end
      default: r_next.st = HPA_IDLE;
    endcase
    // Prefetch only when idle on the memory port and the FIFO has room
    if (r_reg.autoinc && r_next.autoinc && !r_reg.mem_req && !r_next.mem_req
        && !fifo_bus.full && r_reg.st != HPA_FLUSH) begin
      r_next.mem_req  = 1'b1;
      r_next.mem_we   = 1'b0;
      r_next.mem_pf   = 1'b1;
      r_next.mem_addr = r_reg.pf_addr;
      r_next.pf_addr  = r_reg.pf_addr + HPA_ADDR_STEP;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      r_reg          <= '0;
      r_reg.st       <= HPA_IDLE;
      r_reg.strobe_d <= 1'b1;
      r_reg.top      <= HPA_PAGE_RESET;
      r_reg.umid     <= HPA_PAGE_RESET;
    end else begin
      r_reg <= r_next;
    end
  end

  // ==========================================================
  // Outputs
  assign av_readdata_out    = r_reg.av_rdata;
  assign av_waitrequest_out = (av_read_in | av_write_in) & ~r_reg.av_ack;
  assign host_data_out      = r_reg.hdata;
  assign host_data_oe_out   = ~host_strobe_n_in & host_rw_in & host_ready_out;
  assign host_ready_out     = (r_reg.st == HPA_IDLE) || (r_reg.st == HPA_HOLD);
  assign mem_req_out        = r_reg.mem_req;
  assign mem_we_out         = r_reg.mem_we;
  assign mem_addr_out       = r_reg.mem_addr;
  assign mem_wdata_out      = r_reg.wdata;

  // ==========================================================
  // Checks
  // Host-issued request starts: a rising request that is not a prefetch
  top_byte_a: assert property (@(posedge clk_in) disable iff (rst_in)
    $rose(mem_req_out) && !r_reg.mem_pf && page_apply
    |-> mem_addr_out[31:24] == r_reg.top)
    else $error("top page byte not on address bits 31:24");
  umid_byte_a: assert property (@(posedge clk_in) disable iff (rst_in)
    $rose(mem_req_out) && !r_reg.mem_pf && page_apply
    |-> mem_addr_out[23:16] == r_reg.umid)
    else $error("upper-middle byte not on address bits 23:16");
  resv_zero_a: assert property (@(posedge clk_in) disable iff (rst_in)
    r_reg.av_ack && (av_address_in == HPA_TOP_ADDR || av_address_in == HPA_UMID_ADDR)
    |-> av_readdata_out[31:8] == 24'h00_0000)
    else $error("reserved page bits not zero");
  page_reset_a: assert property (@(posedge clk_in)
    rst_in |=> r_reg.top == HPA_PAGE_RESET && r_reg.umid == HPA_PAGE_RESET)
    else $error("page bytes not cleared by reset");
  fetch_wait_a: assert property (@(posedge clk_in) disable iff (rst_in)
    r_reg.st == HPA_IDLE && strobe_fall && host_rw_in && host_cntl_in == HPA_SEL_DATA
    |=> !host_ready_out [*2])
    else $error("plain data read did not hold ready low");
  direct_read_a: assert property (@(posedge clk_in) disable iff (rst_in)
    r_reg.st == HPA_IDLE && strobe_fall && host_rw_in && host_cntl_in != HPA_SEL_DATA
    && (host_cntl_in != HPA_SEL_DATA_AUTO || !fifo_bus.empty) |=> host_ready_out)
    else $error("direct or prefetched read waited");
  flush_wait_a: assert property (@(posedge clk_in) disable iff (rst_in)
    r_reg.st == HPA_IDLE && strobe_fall && !host_rw_in && host_cntl_in == HPA_SEL_ADDR
    && !fifo_bus.empty |=> !host_ready_out)
    else $error("address write with data left did not drop ready");
  low_bits_a: assert property (@(posedge clk_in) disable iff (rst_in)
    $rose(mem_req_out) && !r_reg.mem_pf && r_reg.sep_bus
    |-> mem_addr_out[15:0] == $past(host_addr_in))
    else $error("separate address pins not used");
  mux_page_a: assert property (@(posedge clk_in) disable iff (rst_in)
    $rose(mem_req_out) && !r_reg.mem_pf && r_reg.page_mode && !r_reg.sep_bus
    |-> mem_addr_out == {r_reg.top, r_reg.umid, r_reg.addr[15:0]})
    else $error("paged address not concatenated");
  bus_answer_a: assert property (@(posedge clk_in) disable iff (rst_in)
    av_read_in || av_write_in |-> ##[0:1] !av_waitrequest_out)
    else $error("register bus not answered in one wait cycle");
  fetch_cv: cover property (@(posedge clk_in) disable iff (rst_in)
    r_reg.st == HPA_FETCH ##[1:20] r_reg.st == HPA_HOLD);
  prefetch_cv: cover property (@(posedge clk_in) disable iff (rst_in)
    fifo_bus.pop && r_reg.st == HPA_IDLE);
  flush_cv: cover property (@(posedge clk_in) disable iff (rst_in) fifo_bus.flush);
endmodule : hpa_host_port
`default_nettype wire

// [bench/hpa_mem_model.sv]
/*
  Behavioural internal memory answering the host port block's memory requests.
  Assumes one clock, a request held until acknowledged, one-cycle ack pulses.
*/
`default_nettype none
module hpa_mem_model (
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  // Memory port of the block
  input  wire logic        mem_req_in,
  input  wire logic        mem_we_in,
  input  wire logic [31:0] mem_addr_in,
  input  wire logic [31:0] mem_wdata_in,
  output logic             mem_ack_out,
  output logic      [31:0] mem_rdata_out,
  // Last completed access
  output logic      [31:0] last_addr_out,
  output logic             last_we_out,
  output logic      [31:0] last_wdata_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] wait_reg;
  logic [2:0] slow_reg;
  // ==========================================================
  // Answer after zero to three cycles, so prompt and slow answers both occur
  always_ff @(posedge clk_in) begin
    slow_reg <= slow_reg + 3'h3;
    mem_ack_out <= 1'b0;
    // Read data is not valid outside the ack, so it keeps changing
    mem_rdata_out <= ~mem_rdata_out;
    if (rst_in) begin
      wait_reg <= 2'h0;
      slow_reg <= 3'h0;
      mem_rdata_out <= 32'h0000_0000;
      last_addr_out <= 32'h0000_0000;
      last_we_out <= 1'b0;
      last_wdata_out <= 32'h0000_0000;
    end else if (mem_req_in && !mem_ack_out) begin
      if (wait_reg == 2'h0) begin
        mem_ack_out <= 1'b1;
        mem_rdata_out <= mem_addr_in ^ 32'hc3a5_0f1e;
        last_addr_out <= mem_addr_in;
        last_we_out <= mem_we_in;
        last_wdata_out <= mem_wdata_in;
        wait_reg <= slow_reg[1:0];
      end else begin
        wait_reg <= wait_reg - 2'h1;
      end
    end
  end
endmodule : hpa_mem_model
`default_nettype wire

// [bench/testbench.sv]
/*
  Self-checking bench for the host port page-address block.
  Assumes the block's package and the memory model are compiled first.
*/
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import hpa_pkg::*;
  logic        clk_in, rst_in, av_read_in, av_write_in, av_waitrequest_out;
  logic [31:0] av_address_in, av_writedata_in, av_readdata_out;
  logic [3:0]  av_byteenable_in;
  logic        host_strobe_n_in, host_rw_in, host_data_oe_out, host_ready_out;
  logic [1:0]  host_cntl_in;
  logic [15:0] host_addr_in, seed;
  logic [31:0] host_data_in, host_data_out, mem_addr_out, mem_wdata_out, mem_rdata_in;
  logic        mem_req_out, mem_we_out, mem_ack_in, last_we, low;
  logic [31:0] last_addr, last_wdata, rd, a;
  logic [7:0]  top_b, umid_b;
  int          errors, num_checks, cycles;

  hpa_host_port #(.FIFO_DEPTH(4)) u_hpa_host_port (
    .clk_in(clk_in), .rst_in(rst_in), .av_address_in(av_address_in),
    .av_read_in(av_read_in), .av_write_in(av_write_in), .av_writedata_in(av_writedata_in),
    .av_byteenable_in(av_byteenable_in), .av_readdata_out(av_readdata_out),
    .av_waitrequest_out(av_waitrequest_out), .host_strobe_n_in(host_strobe_n_in),
    .host_cntl_in(host_cntl_in), .host_rw_in(host_rw_in), .host_addr_in(host_addr_in),
    .host_data_in(host_data_in), .host_data_out(host_data_out),
    .host_data_oe_out(host_data_oe_out), .host_ready_out(host_ready_out),
    .mem_req_out(mem_req_out), .mem_we_out(mem_we_out), .mem_addr_out(mem_addr_out),
    .mem_wdata_out(mem_wdata_out), .mem_ack_in(mem_ack_in), .mem_rdata_in(mem_rdata_in));
  hpa_mem_model u_hpa_mem_model (
    .clk_in(clk_in), .rst_in(rst_in), .mem_req_in(mem_req_out), .mem_we_in(mem_we_out),
    .mem_addr_in(mem_addr_out), .mem_wdata_in(mem_wdata_out), .mem_ack_out(mem_ack_in),
    .mem_rdata_out(mem_rdata_in), .last_addr_out(last_addr), .last_we_out(last_we),
    .last_wdata_out(last_wdata));

  initial begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end
  // ==========================================================
  // Helpers
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  function automatic logic [31:0] mem_val(input logic [31:0] addr);
    return addr ^ 32'hc3a5_0f1e;
  endfunction : mem_val
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : close_out
  // Avalon transfer held until waitrequest is seen low
  task automatic av_xfer(input logic wr, input logic [31:0] addr, input logic [31:0] data,
                         input logic [3:0] be, output logic [31:0] rdata);
    @(posedge clk_in);
    av_address_in <= addr;
    av_writedata_in <= data;
    av_byteenable_in <= be;
    av_write_in <= wr;
    av_read_in <= !wr;
    // Only the hang guard ends this wait if waitrequest stays high
    do begin
      @(posedge clk_in);
    end while (av_waitrequest_out !== 1'b0);
    rdata = av_readdata_out;
    av_write_in <= 1'b0;
    av_read_in <= 1'b0;
  endtask : av_xfer
  // Host access; saw_low tells whether ready dropped while the strobe was low
  task automatic host_xfer(input logic [1:0] cntl, input logic rw, input logic [31:0] wdata,
                           output logic [31:0] rdata, output logic saw_low);
    saw_low = 1'b0;
    @(posedge clk_in);
    host_cntl_in <= cntl;
    host_rw_in <= rw;
    host_data_in <= wdata;
    host_strobe_n_in <= 1'b0;
    // The fall is taken at the next edge; ready tells from the edge after
    @(posedge clk_in);
    do begin
      @(posedge clk_in);
      if (host_ready_out !== 1'b1) begin
        saw_low = 1'b1;
      end
    end while (host_ready_out !== 1'b1);
    rdata = host_data_out;
    check("data drive", 32'(host_data_oe_out), 32'(rw));
    host_strobe_n_in <= 1'b1;
    @(posedge clk_in);
    do begin
      @(posedge clk_in);
    end while (host_ready_out !== 1'b1);
    @(posedge clk_in);
  endtask : host_xfer
  // ==========================================================
  // Hang guard, far above the few hundred cycles the tests need
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      close_out();
    end
  end
  // ==========================================================
  // Tests
  initial begin
    {av_read_in, av_write_in, av_address_in, av_writedata_in} = '0;
    {host_rw_in, host_cntl_in, host_addr_in, host_data_in} = '0;
    av_byteenable_in = 4'hf;
    host_strobe_n_in = 1'b1;
    rst_in = 1'b1;
    seed = 16'h00aa;
    {errors, num_checks, cycles} = '0;
    repeat (3) @(posedge clk_in);
    rst_in <= 1'b0;
    av_xfer(1'b0, HPA_TOP_ADDR, 32'h0, 4'hf, rd);
    check("top reset", rd, {24'h0, HPA_PAGE_RESET});
    av_xfer(1'b0, HPA_UMID_ADDR, 32'h0, 4'hf, rd);
    check("umid reset", rd, {24'h0, HPA_PAGE_RESET});
    av_xfer(1'b1, 32'h4000_0014, 32'h0000_00ff, 4'hf, rd);
    av_xfer(1'b0, 32'h4000_0014, 32'h0, 4'hf, rd);
    check("unmapped", rd, HPA_WORD_RESET);
    $display("test reset values done");
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      top_b = seed[7:0];
      seed = lfsr(seed);
      umid_b = seed[15:8];
      // Software keeps the reserved bits zero
      av_xfer(1'b1, HPA_TOP_ADDR, {24'h0, top_b}, 4'hf, rd);
      av_xfer(1'b1, HPA_UMID_ADDR, {24'h0, umid_b}, 4'hf, rd);
      av_xfer(1'b1, HPA_TOP_ADDR, {24'h0, ~top_b}, 4'h0, rd);
      av_xfer(1'b0, HPA_TOP_ADDR, 32'h0, 4'hf, rd);
      check("top readback", rd, {24'h0, top_b});
      av_xfer(1'b0, HPA_UMID_ADDR, 32'h0, 4'hf, rd);
      check("umid readback", rd, {24'h0, umid_b});
    end
    $display("test page registers done");
    av_xfer(1'b1, HPA_CFG_ADDR, 32'h1 << HPA_CFG_SEP_BIT, 4'hf, rd);
    for (int i = 0; i < 3; i++) begin
      seed = lfsr(seed);
      host_addr_in <= seed & 16'hfffc;
      a = {top_b, umid_b, seed & 16'hfffc};
      host_xfer(HPA_SEL_DATA, 1'b1, 32'h0, rd, low);
      check("plain read wait", 32'(low), 32'h1);
      check("plain read addr", last_addr, a);
      check("plain read data", rd, mem_val(a));
    end
    seed = lfsr(seed);
    host_xfer(HPA_SEL_CTRL, 1'b0, {~seed, seed}, rd, low);
    host_xfer(HPA_SEL_CTRL, 1'b1, 32'h0, rd, low);
    check("control read wait", 32'(low), 32'h0);
    check("control read data", rd, {~seed, seed});
    host_xfer(HPA_SEL_ADDR, 1'b1, 32'h0, rd, low);
    check("address read wait", 32'(low), 32'h0);
    check("address read data", rd, HPA_WORD_RESET);
    $display("test separate bus done");
    av_xfer(1'b1, HPA_CFG_ADDR, 32'h1 << HPA_CFG_PAGE_BIT, 4'hf, rd);
    seed = lfsr(seed);
    a = {top_b, umid_b, seed & 16'h0ff0};
    host_xfer(HPA_SEL_ADDR, 1'b0, {~seed, seed & 16'h0ff0}, rd, low);
    check("address write empty", 32'(low), 32'h0);
    seed = lfsr(seed);
    host_xfer(HPA_SEL_DATA, 1'b0, {seed, ~seed}, rd, low);
    check("paged write addr", last_addr, a);
    check("paged write kind", 32'(last_we), 32'h1);
    check("paged write data", last_wdata, {seed, ~seed});
    host_xfer(HPA_SEL_DATA_AUTO, 1'b1, 32'h0, rd, low);
    check("auto empty wait", 32'(low), 32'h1);
    check("auto first data", rd, mem_val(a));
    // Give the prefetch time to fill the FIFO
    repeat (40) @(posedge clk_in);
    host_xfer(HPA_SEL_DATA_AUTO, 1'b1, 32'h0, rd, low);
    check("auto prefetched wait", 32'(low), 32'h0);
    check("auto second data", rd, mem_val(a + HPA_ADDR_STEP));
    host_xfer(HPA_SEL_ADDR, 1'b0, 32'h0000_0100, rd, low);
    check("address write flush", 32'(low), 32'h1);
    $display("test page mode done");
    av_xfer(1'b1, HPA_CFG_ADDR, HPA_WORD_RESET, 4'hf, rd);
    seed = lfsr(seed);
    a = {~seed, seed & 16'hfffc};
    host_xfer(HPA_SEL_ADDR, 1'b0, a, rd, low);
    host_xfer(HPA_SEL_DATA, 1'b1, 32'h0, rd, low);
    check("full address", last_addr, a);
    check("full read data", rd, mem_val(a));
    $display("test full address done");
    close_out();
  end
endmodule : testbench
`default_nettype wire
